/* File: src/core_rf_cfg.svh */
// Register indices, flag-field layout and address constants for the core register file
`ifndef CORE_RF_CFG_SVH
`define CORE_RF_CFG_SVH

// Dedicated register indices
`define RF_IDX_FRAME 4'h0
`define RF_IDX_UPPER 4'h1
`define RF_IDX_STACK 4'hD
`define RF_IDX_FLAGS 4'hE
`define RF_IDX_NULL 4'hF

// Condition flags layout
`define FLAGS_KEEP_MASK 16'hF007
`define FLAGS_LEVEL_ONES 16'h0007
`define FLAGS_N_BIT 15
`define FLAGS_C_BIT 13

// Word constants
`define WORD_ZERO 16'h0000
`define WORD_ONES 16'hFFFF
`define STACK_STEP 16'h0002
`define PC_STEP 16'h0001
`define PC_RESET 16'h0000
`define TRAP_BASE 17'h08000

`endif

/* File: src/core_rf_pkg.sv */
// Types shared by the core register file and its helpers
`default_nettype none
package core_rf_pkg;

  // Commands issued by the instruction decoder
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_WRITE = 4'h1, OP_LONG_WR = 4'h2, OP_SIGN_WIDEN = 4'h3,
    OP_NARROW_CHECK = 4'h4, OP_ROUND_SHR = 4'h5, OP_LINK = 4'h6, OP_UNLINK = 4'h7,
    OP_RET_RELEASE = 4'h8, OP_CALL = 4'h9, OP_RET = 4'hA, OP_TRAP = 4'hB,
    OP_INT_RETURN = 4'hC, OP_PUSH = 4'hD, OP_POP = 4'hE
  } op_e;

  // Sequencer states, Gray along the path
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_ISSUE = 2'b01, S_WAIT = 2'b11, S_FIN = 2'b10
  } seq_state_e;

  // Kind of one stack or vector access
  typedef enum logic [1:0] {ACC_PUSH = 2'b00, ACC_POP = 2'b01, ACC_VEC = 2'b10} acc_kind_e;

  // Decoder command
  typedef struct packed {
    op_e op;
    logic [3:0] rd;
    logic [3:0] rs;
    logic [15:0] imm;
    logic [15:0] lo;
    logic [15:0] hi;
  } cmd_s;

  // Memory request towards the bus unit
  typedef struct packed {
    logic req;
    logic we;
    logic [16:0] addr;
    logic [15:0] wdata;
  } mem_req_s;

  // One sequencer step
  typedef struct packed {
    acc_kind_e kind;
    logic to_pc;
    logic [3:0] idx;
    logic last;
  } desc_s;

endpackage : core_rf_pkg
`default_nettype wire

/* File: src/long_word_unit.sv */
// Combinational 32-bit helpers that use the upper-word register
`include "core_rf_cfg.svh"
`default_nettype none
module long_word_unit (
  // Operand pair
  input wire logic [15:0] upper,
  input wire logic [15:0] lower,
  input wire logic [4:0] shamt,
  // Flags feeding the rounding
  input wire logic neg_flag,
  input wire logic carry_flag,
  // Results
  output logic [31:0] round_res,
  output logic [15:0] sign_word,
  output logic narrow_ok
);
  // Full 32-bit value
  wire logic signed [31:0] long_val = {upper, lower};
  // Arithmetic shift result
  wire logic signed [31:0] shifted = long_val >>> shamt;
  // Rounding increment
  wire logic [31:0] round_inc = {31'h0, neg_flag & carry_flag};

  // Shift then round toward zero
  assign round_res = shifted + round_inc;
  // Sign extension word
  assign sign_word = lower[15] ? `WORD_ONES : `WORD_ZERO;
  // Fits in 16 bits when upper word is pure sign
  assign narrow_ok = (upper == (lower[15] ? `WORD_ONES : `WORD_ZERO));
endmodule : long_word_unit
`default_nettype wire

/* File: src/core_reg_file.sv */
// Sixteen-entry core register file with stack, frame and trap sequencing
`include "core_rf_cfg.svh"
`default_nettype none
module core_reg_file #(
  parameter int REGS = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Decoder command and program flow
  input wire core_rf_pkg::cmd_s cmd,
  input wire logic pc_adv,
  // Read ports
  input wire logic [3:0] rsel_a,
  input wire logic [3:0] rsel_b,
  output logic [15:0] rd_a_q,
  output logic [15:0] rd_b_q,
  // Status to decoder
  output logic busy_q,
  output logic narrow_ok_q,
  // Program fetch address
  output logic [15:0] pc_q,
  output logic [16:0] fetch_addr_q,
  // Stack and vector memory access
  output core_rf_pkg::mem_req_s mem_q,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  import core_rf_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Storage and decoding helpers
  // Register array, no reset on purpose
  logic [15:0] rf_q [REGS];
  // Sequencer state
  seq_state_e state_q, state_d;
  // Held command during sequences
  cmd_s held_q;
  // Step within a sequence
  logic [4:0] step_q;
  // Program counter next value
  logic [15:0] pc_d;
  // Read with null and reserved-bit handling
  function automatic logic [15:0] read_f(input logic [15:0] raw, input logic [3:0] idx);
    if (idx == `RF_IDX_NULL) begin
      read_f = `WORD_ZERO;
    end else if (idx == `RF_IDX_FLAGS) begin
      read_f = raw & `FLAGS_KEEP_MASK;
    end else begin
      read_f = raw;
    end
  endfunction : read_f
  // Step descriptor for each sequenced command
  function automatic desc_s desc_f(input op_e op, input logic [4:0] step, input logic [3:0] lo,
                                   input logic [3:0] hi);
    logic [4:0] span;
    span = {1'b0, hi} - {1'b0, lo};
    desc_f = '{kind: ACC_POP, to_pc: 1'b0, idx: `RF_IDX_FRAME, last: 1'b1};
    unique case (op)
      OP_LINK: desc_f.kind = ACC_PUSH;
      OP_UNLINK: desc_f.kind = ACC_POP;
      OP_RET_RELEASE: begin
        desc_f.to_pc = (step != 5'h00);
        desc_f.last = (step != 5'h00);
      end
      OP_CALL: begin
        desc_f.kind = ACC_PUSH;
        desc_f.to_pc = 1'b1;
      end
      OP_RET: desc_f.to_pc = 1'b1;
      OP_TRAP: begin
        desc_f.kind = (step == 5'h02) ? ACC_VEC : ACC_PUSH;
        desc_f.to_pc = (step != 5'h00);
        desc_f.idx = `RF_IDX_FLAGS;
        desc_f.last = (step == 5'h02);
      end
      OP_INT_RETURN: begin
        desc_f.to_pc = (step == 5'h00);
        desc_f.idx = `RF_IDX_FLAGS;
        desc_f.last = (step != 5'h00);
      end
      OP_PUSH: begin
        desc_f.kind = ACC_PUSH;
        desc_f.idx = lo + step[3:0];
        desc_f.last = (step == span);
      end
      OP_POP: begin
        desc_f.idx = hi - step[3:0];
        desc_f.last = (step == span);
      end
      default: desc_f.last = 1'b1;
    endcase
  endfunction : desc_f
  //////////////////////////////////////////////////////////////////////////////
  // Named views of the dedicated registers
  // Frame base, upper word, stack pointer, flags
  wire logic [15:0] frame_base_reg = rf_q[`RF_IDX_FRAME];
  wire logic [15:0] upper_word_reg = rf_q[`RF_IDX_UPPER];
  wire logic [15:0] stack_pointer = rf_q[`RF_IDX_STACK];
  wire logic [15:0] condition_flags_reg = read_f(rf_q[`RF_IDX_FLAGS], `RF_IDX_FLAGS);
  // Stack pointer moved by one word either way
  wire logic [15:0] sp_up = stack_pointer + `STACK_STEP;
  wire logic [15:0] sp_down = stack_pointer - `STACK_STEP;
  // Command accepted this cycle
  wire logic take = (state_q == S_IDLE) && (cmd.op != OP_NONE);
  // Sequenced command accepted
  wire logic take_seq = take && (cmd.op >= OP_LINK);
  // Operand of a single-cycle long command
  wire logic [15:0] rd_val = read_f(rf_q[cmd.rd], cmd.rd);
  // Current step descriptor
  wire desc_s desc = desc_f(held_q.op, step_q, held_q.rs, held_q.rd);
  // Acknowledged access this cycle
  wire logic acked = (state_q == S_WAIT) && mem_ack;
  // Source word for a push
  wire logic [15:0] push_data = desc.to_pc ? pc_q : read_f(rf_q[desc.idx], desc.idx);
  // Vector address within the 17-bit space
  wire logic [16:0] vec_addr = `TRAP_BASE + {8'h00, held_q.imm[7:0], 1'b0};
  //////////////////////////////////////////////////////////////////////////////
  // Long-word helpers
  // Results of the 32-bit helper
  logic [31:0] round_res;
  logic [15:0] sign_word;
  logic narrow_ok;
  // Shared 32-bit helper
  long_word_unit u_long (
    .upper(upper_word_reg),
    .lower(rd_val),
    .shamt(cmd.imm[4:0]),
    .neg_flag(condition_flags_reg[`FLAGS_N_BIT]),
    .carry_flag(condition_flags_reg[`FLAGS_C_BIT]),
    .round_res(round_res),
    .sign_word(sign_word),
    .narrow_ok(narrow_ok)
  );
  //////////////////////////////////////////////////////////////////////////////
  // Write ports: A for destinations, B for stack and upper word
  // Port controls
  logic wa_en, wb_en;
  logic [3:0] wa_idx, wb_idx;
  logic [15:0] wa_data, wb_data;
  // Select what each write port does this cycle
  always_comb begin
    wa_en = 1'b0;
    wa_idx = cmd.rd;
    wa_data = cmd.lo;
    wb_en = 1'b0;
    wb_idx = `RF_IDX_UPPER;
    wb_data = cmd.hi;
    if (take) begin
      unique case (cmd.op)
        // Plain destination write
        OP_WRITE: wa_en = 1'b1;
        // Long result, high word to upper register
        OP_LONG_WR: begin
          wa_en = 1'b1;
          wb_en = 1'b1;
        end
        // Sign extension into upper register
        OP_SIGN_WIDEN: begin
          wb_en = 1'b1;
          wb_data = sign_word;
        end
        // Rounded long shift
        OP_ROUND_SHR: begin
          wa_en = 1'b1;
          wa_data = round_res[15:0];
          wb_en = 1'b1;
          wb_data = round_res[31:16];
        end
        // Stack takes the frame base first
        OP_UNLINK, OP_RET_RELEASE: begin
          wb_en = 1'b1;
          wb_idx = `RF_IDX_STACK;
          wb_data = frame_base_reg;
        end
        default: wa_en = 1'b0;
      endcase
    end else if (acked) begin
      // Stack pointer follows each push and pop, not the vector fetch
      wb_en = (desc.kind != ACC_VEC);
      wb_idx = `RF_IDX_STACK;
      wb_data = (desc.kind == ACC_PUSH) ? sp_up : sp_down;
      // Popped word lands in its register
      wa_en = (desc.kind == ACC_POP) && !desc.to_pc;
      wa_idx = desc.idx;
      wa_data = mem_rdata;
    end else if (state_q == S_FIN) begin
      wb_idx = `RF_IDX_STACK;
      wa_idx = `RF_IDX_FRAME;
      wa_data = stack_pointer;
      unique case (held_q.op)
        // Frame takes stack, then allocate
        OP_LINK: begin
          wa_en = 1'b1;
          wb_en = 1'b1;
          wb_data = stack_pointer + held_q.imm;
        end
        // Release the displacement
        OP_RET_RELEASE: begin
          wb_en = 1'b1;
          wb_data = stack_pointer - held_q.imm;
        end
        // Raise the level to all ones
        OP_TRAP: begin
          wa_en = 1'b1;
          wa_idx = `RF_IDX_FLAGS;
          wa_data = condition_flags_reg | `FLAGS_LEVEL_ONES;
        end
        default: wa_en = 1'b0;
      endcase
    end
  end

  // Register array update, port A wins on a clash
  always_ff @(posedge clk) begin
    if (wb_en && wb_idx != `RF_IDX_NULL) begin
      rf_q[wb_idx] <= (wb_idx == `RF_IDX_FLAGS) ? (wb_data & `FLAGS_KEEP_MASK) : wb_data;
    end
    if (wa_en && wa_idx != `RF_IDX_NULL) begin
      rf_q[wa_idx] <= (wa_idx == `RF_IDX_FLAGS) ? (wa_data & `FLAGS_KEEP_MASK) : wa_data;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: state_d = take_seq ? S_ISSUE : S_IDLE;
      S_ISSUE: state_d = S_WAIT;
      S_WAIT: state_d = mem_ack ? (desc.last ? S_FIN : S_ISSUE) : S_WAIT;
      S_FIN: state_d = S_IDLE;
    endcase
  end
  // State, held command and step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      held_q <= '0;
      step_q <= 5'h00;
    end else begin
      state_q <= state_d;
      held_q <= take_seq ? cmd : held_q;
      step_q <= take_seq ? 5'h00 : (acked ? step_q + 5'h01 : step_q);
    end
  end
  // Memory request, held until acknowledged
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_q <= '0;
    end else if (state_q == S_ISSUE) begin
      mem_q.req <= 1'b1;
      mem_q.we <= (desc.kind == ACC_PUSH);
      mem_q.wdata <= push_data;
      unique case (desc.kind)
        ACC_PUSH: mem_q.addr <= {1'b0, stack_pointer};
        ACC_POP: mem_q.addr <= {1'b0, sp_down};
        default: mem_q.addr <= vec_addr;
      endcase
    end else if (acked) begin
      mem_q.req <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Program counter and fetch address
  // PC next value
  always_comb begin
    pc_d = pc_q;
    if (state_q == S_IDLE && pc_adv) begin
      pc_d = pc_q + `PC_STEP;
    end else if (acked && desc.to_pc && desc.kind != ACC_PUSH) begin
      pc_d = mem_rdata;
    end else if (state_q == S_FIN && held_q.op == OP_CALL) begin
      pc_d = held_q.imm;
    end
  end
  // PC and the byte fetch address it drives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_q <= `PC_RESET;
      fetch_addr_q <= {`PC_RESET, 1'b0};
    end else begin
      pc_q <= pc_d;
      fetch_addr_q <= {pc_d, 1'b0};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Read ports and status
  // Registered reads and status flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_a_q <= `WORD_ZERO;
      rd_b_q <= `WORD_ZERO;
      busy_q <= 1'b0;
      narrow_ok_q <= 1'b0;
    end else begin
      rd_a_q <= read_f(rf_q[rsel_a], rsel_a);
      rd_b_q <= read_f(rf_q[rsel_b], rsel_b);
      busy_q <= (state_d != S_IDLE);
      narrow_ok_q <= (take && cmd.op == OP_NARROW_CHECK) ? narrow_ok : narrow_ok_q;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Null register reads zero
  null_read_zero_a: assert property (rsel_a == `RF_IDX_NULL |=> rd_a_q == `WORD_ZERO)
    else $error("null register read nonzero");
  // Fetch address is PC shifted, bit 0 low
  fetch_align_a: assert property (fetch_addr_q == {pc_q, 1'b0})
    else $error("fetch address misaligned");
  // Push advances stack by two
  push_step_two_a: assert property (acked && mem_q.we && desc.idx != `RF_IDX_STACK |=>
    stack_pointer == $past(sp_up)) else $error("push step wrong");
  // Trap ends with level all ones
  trap_level_a: assert property (state_q == S_FIN && held_q.op == OP_TRAP |=>
    condition_flags_reg[2:0] == 3'b111) else $error("trap level not raised");
  // Flags never keep reserved bits
  flags_reserved_a: assert property (wa_en && wa_idx == `RF_IDX_FLAGS |=>
    (rf_q[`RF_IDX_FLAGS] & ~`FLAGS_KEEP_MASK) == `WORD_ZERO) else $error("reserved flag kept");
  // Sign widen fills upper register
  widen_upper_a: assert property (take && cmd.op == OP_SIGN_WIDEN && cmd.rd != `RF_IDX_UPPER |=>
    upper_word_reg == $past(sign_word)) else $error("sign widen wrong");
  // Link leaves frame equal to pushed stack
  link_frame_a: assert property (state_q == S_FIN && held_q.op == OP_LINK |=>
    frame_base_reg == $past(stack_pointer)) else $error("link frame wrong");
  // Unlink copies frame into stack first
  unlink_stack_a: assert property (take && cmd.op == OP_UNLINK |=>
    stack_pointer == $past(frame_base_reg)) else $error("unlink stack wrong");
  // Call pushes the return address
  call_push_a: assert property (state_q == S_ISSUE && held_q.op == OP_CALL |=>
    mem_q.we && mem_q.wdata == $past(pc_q)) else $error("call push wrong");
  // Narrow check result registered
  narrow_flag_a: assert property (take && cmd.op == OP_NARROW_CHECK |=>
    narrow_ok_q == $past(narrow_ok)) else $error("narrow check wrong");
  // Interrupt return reaches the finish state within 301 cycles of the command
  iret_len_a: assert property (take && cmd.op == OP_INT_RETURN |=> ##[1:300] state_q == S_FIN
    ) else $error("interrupt return stalled");
endmodule : core_reg_file
`default_nettype wire

/* File: tb/stack_mem_model.sv */
// Word memory model answering the register file's stack and vector requests
`default_nettype none
module stack_mem_model (
  // Clock
  input wire logic clk,
  // Request side
  input wire core_rf_pkg::mem_req_s req,
  input wire logic [1:0] dly,
  // Answer side
  output logic ack,
  output logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import core_rf_pkg::*;
  logic [15:0] mem [int]; // Sparse store keyed by byte address
  int waited; // Cycles the open request has waited
  initial begin
    ack = 1'b0;
    rdata = 16'h5A5A;
    waited = 0;
  end
  // Acknowledge after the chosen delay; a write lands on the acknowledge edge
  always @(posedge clk) begin
    if (ack) begin
      ack <= 1'b0;
      rdata <= ~rdata; // Bus released, so no stale word stays visible
      waited <= 0;
      if (req.we) begin
        mem[int'(req.addr)] = req.wdata;
      end
    end else if (req.req && waited >= int'(dly)) begin
      ack <= 1'b1;
      // Read data travels with the acknowledge
      if (!req.we) begin
        rdata <= mem.exists(int'(req.addr)) ? mem[int'(req.addr)] : 16'hDEAD;
      end
    end else begin
      waited <= req.req ? waited + 1 : 0;
      rdata <= ~rdata; // Idle bus shows a changing pattern
    end
  end
endmodule : stack_mem_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the core register file and its stack sequences
`include "core_rf_cfg.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import core_rf_pkg::*;
  logic clk, sys_rst, pc_adv, busy_q, narrow_ok_q, mem_ack; // Control and status
  logic [3:0] rsel_a, rsel_b; // Read selects
  logic [15:0] rd_a_q, rd_b_q, pc_q, mem_rdata; // Read data and program counter
  logic [16:0] fetch_addr_q; // Fetch byte address
  logic [1:0] dly; // Memory answer delay
  cmd_s cmd; // Decoder command
  mem_req_s mem_q; // Memory request
  logic [15:0] sh [16]; // Expected register contents
  logic [15:0] sv [16]; // Saved copy around push and pop
  logic [15:0] s, p, f, t, v; // Scenario scratch
  logic [31:0] r; // Long result
  int failures, checks_done, cycles, lo_i, hi_i;

  core_reg_file i_core_reg_file (.clk(clk), .sys_rst(sys_rst), .cmd(cmd), .pc_adv(pc_adv), .rsel_a(rsel_a),
    .rsel_b(rsel_b), .rd_a_q(rd_a_q), .rd_b_q(rd_b_q), .busy_q(busy_q), .narrow_ok_q(narrow_ok_q), .pc_q(pc_q),
    .fetch_addr_q(fetch_addr_q), .mem_q(mem_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  stack_mem_model i_stack_mem_model (.clk(clk), .req(mem_q), .dly(dly), .ack(mem_ack), .rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and expectation helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  function automatic logic [31:0] round_shr(logic [31:0] x, logic [4:0] n, logic [15:0] fl);
    logic [31:0] y;
    y = $signed(x) >>> n;
    return y + {31'h0, fl[`FLAGS_N_BIT] & fl[`FLAGS_C_BIT]};
  endfunction : round_shr
  function automatic logic [15:0] memw(logic [15:0] a);
    return i_stack_mem_model.mem[int'({1'b0, a})];
  endfunction : memw

  ////////////////////////////////////////////////////////////////////////////////
  // Drivers: one nanosecond after the edge, wait out busy with a bound
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic issue(input op_e op, input logic [3:0] rd, input logic [3:0] rs, input logic [15:0] imm,
                       input logic [15:0] lo, input logic [15:0] hi);
    int n;
    cmd = '{op, rd, rs, imm, lo, hi};
    dly = 2'($urandom_range(3));
    step();
    // A write offered while busy must be dropped
    cmd = '{(op >= OP_LINK) ? OP_WRITE : OP_NONE, 4'hC, 4'h0, 16'h0000, ~sh[12], 16'h0000};
    n = 0;
    while (busy_q === 1'b1 && n < 300) begin
      step();
      n++;
    end
    cmd.op = OP_NONE;
    check("busy", busy_q, 1'b0);
    step();
  endtask : issue
  task automatic wr(input int i, input logic [15:0] x);
    issue(OP_WRITE, 4'(i), 4'h0, 16'h0000, x, 16'h0000);
    sh[i] = (i == 15) ? 16'h0000 : (i == 14) ? (x & `FLAGS_KEEP_MASK) : x;
  endtask : wr
  task automatic cmp_all();
    for (int i = 0; i < 16; i++) begin
      rsel_a = 4'(i);
      rsel_b = 4'(i);
      step();
      check("port a", rd_a_q, sh[i]);
      check("port b", rd_b_q, sh[i]);
    end
  endtask : cmp_all

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h83C86DFA));
    {pc_adv, rsel_a, rsel_b, dly} = '0;
    cmd = '0;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    check("reset pc", pc_q, `PC_RESET);
    check("reset fetch", fetch_addr_q, {`PC_RESET, 1'b0});
    check("reset busy", busy_q, 32'h0);
    check("reset request", {mem_q.req, mem_q.we}, 32'h0);
    // Fill every register, set the stack pointer, then the corners of the flag and null registers
    for (int i = 0; i < 16; i++) wr(i, 16'($urandom));
    wr(13, 16'h2000);
    wr(14, 16'hFFFF);
    wr(15, 16'hFFFF);
    cmp_all();
    // A second reset leaves the file alone
    sys_rst = 1'b1;
    step();
    step();
    sys_rst = 1'b0;
    cmp_all();
    // Program counter stepping and the fetch address
    lo_i = $urandom_range(20, 1);
    pc_adv = 1'b1;
    repeat (lo_i) step();
    pc_adv = 1'b0;
    check("pc steps", pc_q, 16'(lo_i));
    check("fetch", fetch_addr_q, {16'(lo_i), 1'b0});
    // Long operations through the upper register
    for (int i = 0; i < 20; i++) begin
      hi_i = $urandom_range(12, 2);
      t = (i < 2) ? {i[0], 15'h0} : 16'($urandom);
      v = 16'($urandom);
      issue(OP_LONG_WR, 4'(hi_i), 4'h0, 16'h0000, t, v);
      sh[hi_i] = t;
      sh[1] = v;
      wr(14, (i % 3 == 0) ? 16'hA000 : 16'($urandom));
      lo_i = (i % 4 == 0) ? 31 : $urandom_range(31);
      r = round_shr({v, t}, 5'(lo_i), sh[14]);
      issue(OP_ROUND_SHR, 4'(hi_i), 4'h0, 16'(lo_i), 16'h0000, 16'h0000);
      sh[1] = r[31:16];
      sh[hi_i] = r[15:0];
      cmp_all();
      issue(OP_SIGN_WIDEN, 4'(hi_i), 4'h0, 16'h0000, 16'h0000, 16'h0000);
      sh[1] = {16{sh[hi_i][15]}};
      cmp_all();
      issue(OP_NARROW_CHECK, 4'(hi_i), 4'h0, 16'h0000, 16'h0000, 16'h0000);
      check("narrow fits", narrow_ok_q, 1'b1);
      wr(1, sh[1] ^ 16'h0001);
      issue(OP_NARROW_CHECK, 4'(hi_i), 4'h0, 16'h0000, 16'h0000, 16'h0000);
      check("narrow loses", narrow_ok_q, 1'b0);
    end
    // Call and return, the top word address among them
    for (int i = 0; i < 4; i++) begin
      t = (i == 0) ? 16'hFFFF : 16'($urandom);
      s = sh[13];
      p = pc_q;
      issue(OP_CALL, 4'h0, 4'h0, t, 16'h0000, 16'h0000);
      check("call push", memw(s), p);
      check("call pc", pc_q, t);
      check("call fetch", fetch_addr_q, {t, 1'b0});
      sh[13] = s + 16'h0002;
      cmp_all();
      issue(OP_RET, 4'h0, 4'h0, 16'h0000, 16'h0000, 16'h0000);
      check("ret pc", pc_q, p);
      sh[13] = s;
      cmp_all();
    end
    // Frame link and unlink
    s = sh[13];
    f = sh[0];
    t = {9'h0, 6'($urandom), 1'b0};
    issue(OP_LINK, 4'h0, 4'h0, t, 16'h0000, 16'h0000);
    check("link push", memw(s), f);
    sh[0] = s + 16'h0002;
    sh[13] = s + 16'h0002 + t;
    cmp_all();
    issue(OP_UNLINK, 4'h0, 4'h0, 16'h0000, 16'h0000, 16'h0000);
    sh[0] = f;
    sh[13] = s;
    cmp_all();
    // Call, link, then return and release
    p = pc_q;
    v = {11'h0, 4'($urandom), 1'b0};
    issue(OP_CALL, 4'h0, 4'h0, 16'($urandom), 16'h0000, 16'h0000);
    issue(OP_LINK, 4'h0, 4'h0, t, 16'h0000, 16'h0000);
    issue(OP_RET_RELEASE, 4'h0, 4'h0, v, 16'h0000, 16'h0000);
    check("release pc", pc_q, p);
    sh[13] = s - v;
    cmp_all();
    wr(13, s);
    // Traps, first and last vector included, each undone by an interrupt return
    for (int i = 0; i < 4; i++) begin
      lo_i = (i == 0) ? 0 : (i == 1) ? 255 : $urandom_range(255);
      v = 16'($urandom);
      i_stack_mem_model.mem[int'(`TRAP_BASE) + 2 * lo_i] = v;
      wr(14, 16'($urandom) & 16'hFFF8);
      f = sh[14];
      p = pc_q;
      issue(OP_TRAP, 4'h0, 4'h0, 16'(lo_i), 16'h0000, 16'h0000);
      check("trap flags push", memw(s), f);
      check("trap pc push", memw(s + 16'h0002), p);
      check("trap vector", pc_q, v);
      sh[14] = f | `FLAGS_LEVEL_ONES;
      sh[13] = s + 16'h0004;
      cmp_all();
      issue(OP_INT_RETURN, 4'h0, 4'h0, 16'h0000, 16'h0000, 16'h0000);
      check("int return pc", pc_q, p);
      sh[14] = f;
      sh[13] = s;
      cmp_all();
    end
    // Push and pop a register range, a single register first
    for (int i = 0; i < 3; i++) begin
      lo_i = $urandom_range(8, 2);
      hi_i = (i == 0) ? lo_i : lo_i + $urandom_range(4, 1);
      sv = sh;
      issue(OP_PUSH, 4'(hi_i), 4'(lo_i), 16'h0000, 16'h0000, 16'h0000);
      for (int k = lo_i; k <= hi_i; k++) check("push word", memw(s + 16'(2 * (k - lo_i))), sh[k]);
      sh[13] = s + 16'(2 * (hi_i - lo_i + 1));
      cmp_all();
      for (int k = lo_i; k <= hi_i; k++) wr(k, 16'($urandom));
      issue(OP_POP, 4'(hi_i), 4'(lo_i), 16'h0000, 16'h0000, 16'h0000);
      sh = sv;
      cmp_all();
    end
    end_of_test();
  end
endmodule : tb
`default_nettype wire
